/* File: shared/aipd_pkg.sv */
/*
 * Constants, codes and lookups for the analog input parameter and
 * diagnostic register bank.
 * Assumes it is compiled before the design files that name it.
 */
`default_nettype none
package aipd_pkg;
    // ************************************************************
    // Sizes
    // ************************************************************
    localparam int NUM_CH   = 8;
    localparam int NUM_PAIR = 4;
    // ************************************************************
    // Address map: parameter area and diagnostic area
    // ************************************************************
    localparam logic [4:0] PAR_BASE  = 5'h00; // Parameter bytes 0..9
    localparam logic [4:0] DIAG_BASE = 5'h10; // Diagnostic bytes 0..11
    localparam logic [3:0] OFS_WB_IRQ = 4'h0; // Wire break and irq enable
    localparam logic [3:0] OFS_P_RSVD = 4'h1; // Reserved parameter byte
    localparam logic [3:0] OFS_FUNC0  = 4'h2; // First function byte
    localparam logic [3:0] OFS_RATE0  = 4'h6; // First option byte
    localparam logic [3:0] OFS_P_LAST = 4'h9; // Last parameter byte
    localparam logic [3:0] OFS_D_LAST = 4'hB; // Last diagnostic byte
    localparam logic [3:0] OFS_D_LOST = 4'h3; // Lost alarm byte
    // ************************************************************
    // Reset values, masks and fixed diagnostic contents
    // ************************************************************
    localparam logic [7:0] WB_IRQ_RST  = 8'h0F;
    localparam logic [7:0] WB_IRQ_MASK = 8'h4F;
    localparam logic [7:0] FUNC_RST    = 8'h26;
    localparam logic [7:0] RATE_RST    = 8'h00;
    localparam logic [7:0] RATE_MASK   = 8'h0F;
    localparam logic [7:0] FUNC_KEEP   = 8'h00;
    localparam logic [7:0] FUNC_OFF    = 8'hFF;
    localparam logic [7:0] CLASS_BYTE  = 8'h15;
    localparam logic [7:0] CH_TYPE     = 8'h71;
    localparam logic [7:0] DIAG_BITS   = 8'h04;
    localparam logic [7:0] CH_COUNT    = 8'h08;
    // ************************************************************
    // Bit positions
    // ************************************************************
    localparam int IRQ_EN_BIT  = 6;
    localparam int ERR_MOD_BIT = 0;
    localparam int ERR_EXT_BIT = 2;
    localparam int ERR_CH_BIT  = 3;
    localparam int ERR_PAR_BIT = 7;
    localparam int LOST_BIT    = 6;
    localparam logic [1:0] MSG_LAST = 2'h3; // Index of last message byte
    // ************************************************************
    // Message sender states
    // ************************************************************
    typedef enum logic [0:0] {
        MSG_IDLE = 1'b0,
        MSG_SEND = 1'b1
    } aipd_msg_t;
    // ************************************************************
    // Lookups
    // ************************************************************
    // Known measurement function numbers
    function automatic logic func_valid(input logic [7:0] f);
        case (f)
            8'h01, 8'h61, 8'h09, 8'h69, 8'h10, 8'h40, 8'h11, 8'h41,
            8'h14, 8'h44, 8'h18, 8'h48, 8'h19, 8'h49, 8'h1C, 8'h4C,
            8'h26, 8'h56, 8'hFF: func_valid = 1'b1;
            default:            func_valid = 1'b0;
        endcase
    endfunction
    // Four-wire functions use only the even channel
    function automatic logic func_4wire(input logic [7:0] f);
        func_4wire = (f == 8'h09) || (f == 8'h69);
    endfunction
    // Effective resolution in bits for a rate code
    function automatic logic [4:0] res_bits(input logic [3:0] r);
        case (r)
            4'h2:    res_bits = 5'h0F;
            4'h3:    res_bits = 5'h0E;
            4'h4:    res_bits = 5'h0C;
            4'h5:    res_bits = 5'h0A;
            default: res_bits = 5'h10;
        endcase
    endfunction
endpackage
`default_nettype wire

/* File: design/aipd_bank.sv */
/*
 * Parameter and diagnostic register bank of an eight-channel analog
 * input module, with the diagnostic message sender.
 * Assumes a single 100 MHz clock, a plain register port driven on the
 * same clock, a non-volatile store beside it, and a front end that
 * reports per-channel fault levels on the same clock.
 */
// Decided for this implementation: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - Ten-byte parameter area, one setting per pair
// - Byte zero bits 0-3 enable wire break
// - Bit 6 enables four-byte diagnostic message
// - Bytes two-five hold pair function, default 26h
// - Option bits 3-0 choose conversion rate
// - Rate code sets effective resolution bits
// - Per-channel rate divided by delivering channels
// - Four-wire pairs deliver only even channel
// - Twelve diagnostic bytes in two record sets
// - Record zero: four bytes, sent on error, head byte without external bit
// - Diag byte zero: module, external, channel, parameter
// - Diag byte one reads 15h
// - Byte two unused, byte three lost alarm
// - Record one: record zero plus eight bytes
// - Diag byte four reports channel type 71h
// - Bytes five, six report 04h and 08h
// - Byte seven: channel n error at bit n
// - Bytes 8-11: two channels, four flags each
// - Function 00h keeps the stored function
// - Function FFh switches the channel off
module aipd_bank #(
    parameter int ADDR_W = 5
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              arst_n,
    // Register port
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [7:0]        reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [7:0]        reg_rdata,
    // Non-volatile store: restore in, save out
    input  wire logic              nv_load,
    input  wire logic [3:0]        nv_load_addr,
    input  wire logic [7:0]        nv_load_data,
    output logic                   nv_save,
    output logic      [3:0]        nv_save_addr,
    output logic      [7:0]        nv_save_data,
    // Front end fault levels, one bit per channel
    input  wire logic [7:0]        fe_wire_break,
    input  wire logic [7:0]        fe_underflow,
    input  wire logic [7:0]        fe_overflow,
    // Configuration to the front end
    output logic      [7:0]        wb_detect_en,
    output logic      [7:0]        chan_active,
    output logic      [7:0]        chan_deliver,
    output logic      [3:0]        active_count,
    output logic      [31:0]       pair_func,
    output logic      [15:0]       pair_rate,
    output logic      [19:0]       pair_res,
    // Diagnostic message to the master
    output logic                   msg_valid,
    output logic      [7:0]        msg_data,
    input  wire logic              msg_ready
);
    // ************************************************************
    // Reset release
    // ************************************************************
    logic rst_s1;  // First stage
    logic rst_n;   // Released reset used everywhere

    // Two-stage release of the asynchronous reset
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_s1 <= 1'b0;
            rst_n  <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_n  <= rst_s1;
        end
    end

    // ************************************************************
    // Address decode
    // ************************************************************
    wire logic [3:0] ofs      = reg_addr[3:0];
    wire logic       in_par   = (reg_addr[4] == aipd_pkg::PAR_BASE[4])
                                && (ofs <= aipd_pkg::OFS_P_LAST);
    wire logic       in_diag  = (reg_addr[4] == aipd_pkg::DIAG_BASE[4])
                                && (ofs <= aipd_pkg::OFS_D_LAST);
    // Host writes take priority over a restore in the same cycle
    wire logic       wr_host  = reg_wr && in_par;
    wire logic       wr_any   = wr_host || nv_load;
    wire logic [3:0] wr_ofs   = wr_host ? ofs : nv_load_addr;
    wire logic [7:0] wr_data  = wr_host ? reg_wdata : nv_load_data;

    // ************************************************************
    // Parameter area
    // ************************************************************
    logic [7:0] wb_irq;                       // Parameter byte zero
    logic [7:0] func [aipd_pkg::NUM_PAIR];    // Function per pair
    logic [7:0] rate [aipd_pkg::NUM_PAIR];    // Option per pair

    // Byte zero keeps only defined bits
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_irq <= aipd_pkg::WB_IRQ_RST;
        end else if (wr_any && wr_ofs == aipd_pkg::OFS_WB_IRQ) begin
            wb_irq <= wr_data & aipd_pkg::WB_IRQ_MASK;
        end
    end

    // Per-pair settings and derived per-channel controls
    logic [7:0] act_w;   // Channel active
    logic [7:0] dlv_w;   // Channel delivers values
    logic [7:0] wbe_w;   // Wire break check enabled
    logic [3:0] perr_w;  // Pair parameter error
    logic [19:0] res_w;  // Pair resolution

    genvar p;
    generate
        for (p = 0; p < aipd_pkg::NUM_PAIR; p++) begin : g_pair
            localparam logic [3:0] FOFS = aipd_pkg::OFS_FUNC0 + 4'(p);
            localparam logic [3:0] ROFS = aipd_pkg::OFS_RATE0 + 4'(p);
            wire logic on_w = (func[p] != aipd_pkg::FUNC_OFF);

            // Function byte; a zero write keeps the held value
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    func[p] <= aipd_pkg::FUNC_RST;
                end else if (wr_any && wr_ofs == FOFS
                             && wr_data != aipd_pkg::FUNC_KEEP) begin
                    func[p] <= wr_data;
                end
            end

            // Option byte keeps only the rate field
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    rate[p] <= aipd_pkg::RATE_RST;
                end else if (wr_any && wr_ofs == ROFS) begin
                    rate[p] <= wr_data & aipd_pkg::RATE_MASK;
                end
            end

            // Both channels of the pair share the settings
            assign act_w[2*p]   = on_w;
            assign act_w[2*p+1] = on_w;
            assign dlv_w[2*p]   = on_w;
            assign dlv_w[2*p+1] = on_w && !aipd_pkg::func_4wire(func[p]);
            assign wbe_w[2*p]   = wb_irq[p] && on_w;
            assign wbe_w[2*p+1] = wb_irq[p] && dlv_w[2*p+1];
            assign perr_w[p]    = on_w && (!aipd_pkg::func_valid(func[p])
                                  || rate[p][3]);
            assign res_w[5*p +: 5] = aipd_pkg::res_bits(rate[p][3:0]);
        end
    endgenerate

    // Count of delivering channels, the divisor of the conversion rate
    logic [3:0] cnt_w;
    always_comb begin
        cnt_w = 4'h0;
        for (int i = 0; i < aipd_pkg::NUM_CH; i++) begin
            cnt_w = cnt_w + {3'h0, dlv_w[i]};
        end
    end

    // ************************************************************
    // Diagnostic flags
    // ************************************************************
    logic [7:0]  ch_err_w;   // Per-channel error summary
    logic [31:0] det_w;      // Bytes eight to eleven
    genvar c;
    generate
        for (c = 0; c < aipd_pkg::NUM_CH; c++) begin : g_ch
            wire logic wb_f = fe_wire_break[c] && wbe_w[c];
            wire logic pe_f = perr_w[c/2];
            wire logic uf_f = fe_underflow[c] && dlv_w[c] && !pe_f;
            wire logic of_f = fe_overflow[c] && dlv_w[c] && !pe_f;
            // Off channels report nothing
            assign det_w[4*c +: 4] = {of_f, uf_f, pe_f, wb_f};
            assign ch_err_w[c]     = |det_w[4*c +: 4];
        end
    endgenerate

    logic [31:0] det_q;     // Registered detail flags
    logic [7:0]  ch_err_q;  // Registered channel errors
    logic        lost;      // Lost alarm flag

    // Diagnostic byte zero from the registered flags
    logic [7:0] d0_w;
    always_comb begin
        d0_w = 8'h00;
        d0_w[aipd_pkg::ERR_CH_BIT]  = |ch_err_q;
        d0_w[aipd_pkg::ERR_EXT_BIT] = |(det_q & 32'hDDDD_DDDD);
        d0_w[aipd_pkg::ERR_PAR_BIT] = |(det_q & 32'h2222_2222);
        d0_w[aipd_pkg::ERR_MOD_BIT] = |ch_err_q;
    end
    wire logic [7:0] d3_w = {1'b0, lost, 6'h00};

    // Record set one: record zero then module detail
    logic [7:0] diag_w [12];
    assign diag_w[0]  = d0_w;
    assign diag_w[1]  = aipd_pkg::CLASS_BYTE;
    assign diag_w[2]  = 8'h00;
    assign diag_w[3]  = d3_w;
    assign diag_w[4]  = aipd_pkg::CH_TYPE;
    assign diag_w[5]  = aipd_pkg::DIAG_BITS;
    assign diag_w[6]  = aipd_pkg::CH_COUNT;
    assign diag_w[7]  = ch_err_q;
    assign diag_w[8]  = det_q[7:0];
    assign diag_w[9]  = det_q[15:8];
    assign diag_w[10] = det_q[23:16];
    assign diag_w[11] = det_q[31:24];

    // ************************************************************
    // Read path
    // ************************************************************
    logic [7:0] par_rd_w;
    always_comb begin
        case (ofs)
            4'h0:    par_rd_w = wb_irq;
            4'h2:    par_rd_w = func[0];
            4'h3:    par_rd_w = func[1];
            4'h4:    par_rd_w = func[2];
            4'h5:    par_rd_w = func[3];
            4'h6:    par_rd_w = rate[0];
            4'h7:    par_rd_w = rate[1];
            4'h8:    par_rd_w = rate[2];
            4'h9:    par_rd_w = rate[3];
            default: par_rd_w = 8'h00;
        endcase
    end
    wire logic [7:0] rd_w = in_par  ? par_rd_w :
                            in_diag ? diag_w[ofs] : 8'h00;
    wire logic rd_lost = reg_rd && in_diag && ofs == aipd_pkg::OFS_D_LOST;

    // Read data stand in the cycle after the strobe only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= reg_rd ? rd_w : 8'h00;
        end
    end

    // ************************************************************
    // Non-volatile save and registered outputs
    // ************************************************************
    // Every accepted host write except to the reserved byte is copied to the store
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            nv_save      <= 1'b0;
            nv_save_addr <= 4'h0;
            nv_save_data <= 8'h00;
        end else begin
            nv_save      <= wr_host && ofs != aipd_pkg::OFS_P_RSVD;
            nv_save_addr <= ofs;
            nv_save_data <= reg_wdata;
        end
    end

    // Front end controls and flag registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_detect_en <= 8'h00;
            chan_active  <= 8'h00;
            chan_deliver <= 8'h00;
            active_count <= 4'h0;
            pair_func    <= 32'h0000_0000;
            pair_rate    <= 16'h0000;
            pair_res     <= 20'h0_0000;
            det_q        <= 32'h0000_0000;
            ch_err_q     <= 8'h00;
        end else begin
            wb_detect_en <= wbe_w;
            chan_active  <= act_w;
            chan_deliver <= dlv_w;
            active_count <= cnt_w;
            pair_func    <= {func[3], func[2], func[1], func[0]};
            pair_rate    <= {rate[3][3:0], rate[2][3:0],
                             rate[1][3:0], rate[0][3:0]};
            pair_res     <= res_w;
            det_q        <= det_w;
            ch_err_q     <= ch_err_w;
        end
    end

    // ************************************************************
    // Diagnostic message sender
    // ************************************************************
    aipd_pkg::aipd_msg_t state;     // Sender state
    logic [1:0]          idx;       // Byte being offered
    logic [7:0]          snap [4];  // Frozen record zero
    // A new flag rising is an error event
    wire logic new_err = |(det_w & ~det_q);
    wire logic irq_en  = wb_irq[aipd_pkg::IRQ_EN_BIT];
    wire logic start   = irq_en && new_err && state == aipd_pkg::MSG_IDLE;
    wire logic miss    = irq_en && new_err && state == aipd_pkg::MSG_SEND;

    // Lost alarm: a new event while busy; set wins over read clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lost <= 1'b0;
        end else if (miss) begin
            lost <= 1'b1;
        end else if (rd_lost) begin
            lost <= 1'b0;
        end
    end

    // Offer four bytes in order, each held until taken
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state     <= aipd_pkg::MSG_IDLE;
            idx       <= 2'h0;
            msg_valid <= 1'b0;
            msg_data  <= 8'h00;
            for (int i = 0; i < 4; i++) begin
                snap[i] <= 8'h00;
            end
        end else begin
            case (state)
                aipd_pkg::MSG_IDLE: begin
                    if (start) begin
                        // Freeze record bytes one to three; the head byte leaves out the external error bit
                        snap[1]   <= aipd_pkg::CLASS_BYTE;
                        snap[2]   <= 8'h00;
                        snap[3]   <= d3_w;
                        state     <= aipd_pkg::MSG_SEND;
                        idx       <= 2'h0;
                        msg_valid <= 1'b1;
                        msg_data  <= {|(det_w & 32'h2222_2222), 3'h0, 4'h9};
                    end
                end
                aipd_pkg::MSG_SEND: begin
                    if (msg_ready) begin
                        if (idx == aipd_pkg::MSG_LAST) begin
                            state     <= aipd_pkg::MSG_IDLE;
                            msg_valid <= 1'b0;
                            msg_data  <= 8'h00;
                        end else begin
                            idx      <= idx + 2'h1;
                            msg_data <= snap[idx + 2'h1];
                        end
                    end
                end
                default: begin
                    state     <= aipd_pkg::MSG_IDLE;
                    msg_valid <= 1'b0;
                end
            endcase
        end
    end
endmodule // aipd_bank
`default_nettype wire

/* File: bench/aipd_bank_properties.sv */
/* Port checker for the bank.
   Assumes one clock domain and binding into aipd_bank. */
`timescale 1ns/100ps
`default_nettype none
module aipd_bank_properties #(
    parameter int ADDR_W = 5
) (
    // Watched ports
    input wire logic              clk,
    input wire logic              arst_n,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [7:0]        reg_wdata,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [7:0]        reg_rdata,
    input wire logic              nv_load,
    input wire logic              nv_save,
    input wire logic [7:0]        nv_save_data,
    input wire logic [7:0]        chan_active,
    input wire logic [15:0]       pair_rate,
    input wire logic [19:0]       pair_res,
    input wire logic              msg_valid,
    input wire logic [7:0]        msg_data,
    input wire logic              msg_ready
);
    // ****************************************
    // Assertions
    // ****************************************
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    class_byte_a: assert property (reg_rd && reg_addr == 5'h11 |=> reg_rdata == 8'h15)
        else $error("class byte wrong");
    chan_type_a: assert property (reg_rd && reg_addr == 5'h14 |=> reg_rdata == 8'h71)
        else $error("type wrong");
    chan_count_a: assert property (reg_rd && reg_addr == 5'h16 |=> reg_rdata == 8'h08)
        else $error("count wrong");
    rsvd_read_a: assert property (reg_rd && reg_addr == 5'h01 |=> reg_rdata == 8'h00)
        else $error("reserved not zero");
    save_echo_a: assert property (reg_wr && reg_addr == 5'h02
        |=> nv_save && nv_save_data == $past(reg_wdata))
        else $error("store copy missing");
    rsvd_nosave_a: assert property (reg_wr && reg_addr == 5'h01 |=> !nv_save)
        else $error("reserved write saved");
    chan_off_a: assert property (reg_wr && reg_addr == 5'h02 && reg_wdata == 8'hFF
        ##1 !reg_wr && !nv_load |=> chan_active[1:0] == 2'b00)
        else $error("pair still on");
    rate_res_a: assert property (pair_rate[7:4] == 4'h5 |-> pair_res[9:5] == 5'h0A)
        else $error("resolution wrong");
    msg_hold_a: assert property (msg_valid && !msg_ready |=> msg_valid && $stable(msg_data))
        else $error("byte dropped");
    msg_head_a: assert property ($rose(msg_valid) |-> msg_data[6:0] == 7'h09)
        else $error("message head wrong");
endmodule // aipd_bank_properties
bind aipd_bank aipd_bank_properties #(.ADDR_W(ADDR_W)) aipd_bank_properties_i (.*);
`default_nettype wire

/* File: bench/aipd_master_model.sv */
/* Master that takes the diagnostic message bytes.
   Assumes the bank clock; the bench sets the pace. */
`timescale 1ns/100ps
`default_nettype none
module aipd_master_model (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       arst_n,
    // Message handshake
    input  wire logic       msg_valid,
    input  wire logic [7:0] msg_data,
    output logic            msg_ready,
    // Pace and capture
    input  wire logic       slow,
    output logic [31:0]     got,
    output int              got_n
);
    // Stall while slow; newest byte on top
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            msg_ready <= 1'b0;
            got       <= '0;
            got_n     <= 0;
        end else begin
            msg_ready <= !slow;
            if (msg_valid && msg_ready) begin
                got   <= {msg_data, got[31:8]};
                got_n <= got_n + 1;
            end
        end
    end
endmodule // aipd_master_model
`default_nettype wire

/* File: bench/aipd_bank_tb.sv */
/* Self-checking bench of the parameter and diagnostic bank.
   Assumes model and checker are compiled before it. */
`timescale 1ns/100ps
`default_nettype none
module aipd_bank_tb;
    // ****************************************
    // Signals and instances
    // ****************************************
    logic        clk, arst_n, reg_wr, reg_rd, nv_load, slow, msg_valid, msg_ready;
    logic [4:0]  reg_addr;
    logic [7:0]  reg_wdata, nv_load_data, reg_rdata, msg_data;
    logic [3:0]  nv_load_addr, active_count;
    logic [7:0]  fe_wire_break, fe_underflow, fe_overflow;
    logic [7:0]  wb_detect_en, chan_active, chan_deliver;
    logic [31:0] pair_func, got, seed, x;
    logic [15:0] pair_rate;
    logic [19:0] pair_res;
    logic [7:0]  par [10];                // Parameter shadow
    logic [7:0]  fn [8] = '{8'h09, 8'hFF, 8'h69, 8'h56, 8'hFF, 8'h00, 8'h01, 8'h10};
    int          n_mismatch, total_checks, got_n, n0;
    aipd_bank aipd_bank_i (.clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .nv_load, .nv_load_addr, .nv_load_data, .nv_save(), .nv_save_addr(),
        .nv_save_data(), .fe_wire_break, .fe_underflow, .fe_overflow, .wb_detect_en,
        .chan_active, .chan_deliver, .active_count, .pair_func, .pair_rate, .pair_res,
        .msg_valid, .msg_data, .msg_ready);
    aipd_master_model aipd_master_model_i (.*);
    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ****************************************
    // Expectations and bus tasks
    // ****************************************
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Quiet-bank read value
    function automatic logic [7:0] exp_rd(input logic [4:0] a);
        if (a < 5'h0A) return par[a];
        return a == 5'h11 ? 8'h15 : a == 5'h14 ? 8'h71 :
               a == 5'h15 ? 8'h04 : a == 5'h16 ? 8'h08 : 8'h00;
    endfunction
    function automatic logic [4:0] res_of(input logic [3:0] r);
        return r == 2 ? 5'h0F : r == 3 ? 5'h0E : r == 4 ? 5'h0C : r == 5 ? 5'h0A : 5'h10;
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, g);
        total_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Write; shadow masked alike
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        if (a == 5'h00) par[0] = d & 8'h4F;
        else if (a >= 5'h02 && a <= 5'h05 && d != 8'h00) par[a] = d;
        else if (a >= 5'h06 && a <= 5'h09) par[a] = d & 8'h0F;
    endtask
    // Read; data taken next cycle
    task automatic rc(input logic [4:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk("reg_rdata", e, reg_rdata);
    endtask
    // Derived outputs vs shadow
    task automatic chk_cfg();
        logic [7:0]  act = '0, dlv = '0, wb = '0;
        logic [19:0] res = '0;
        logic [3:0]  cnt = '0;
        repeat (2) @(posedge clk);
        for (int p = 0; p < 4; p++) begin
            act[2*p +: 2] = {2{par[2+p] != 8'hFF}};
            dlv[2*p]      = act[2*p];
            dlv[2*p+1]    = act[2*p] && par[2+p] != 8'h09 && par[2+p] != 8'h69;
            wb[2*p +: 2]  = dlv[2*p +: 2] & {2{par[0][p]}};
            res[5*p +: 5] = res_of(par[6+p][3:0]);
            cnt           = cnt + 4'(dlv[2*p]) + 4'(dlv[2*p+1]);
        end
        #1 chk("pair_func", {par[5], par[4], par[3], par[2]}, pair_func);
        chk("pair_rate", {par[9][3:0], par[8][3:0], par[7][3:0], par[6][3:0]}, pair_rate);
        chk("pair_res", res, pair_res);
        chk("chan_active", act, chan_active);
        chk("chan_deliver", dlv, chan_deliver);
        chk("active_count", cnt, active_count);
        chk("wb_detect_en", wb, wb_detect_en);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // ****************************************
    // Tests
    // ****************************************
    initial begin
        seed = 32'd21;
        {reg_wr, reg_rd, nv_load, slow, reg_addr, reg_wdata} = '0;
        {nv_load_addr, nv_load_data, fe_wire_break, fe_underflow, fe_overflow} = '0;
        par = '{8'h0F, 8'h00, 8'h26, 8'h26, 8'h26, 8'h26, 8'h00, 8'h00, 8'h00, 8'h00};
        arst_n = 1'b0;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        for (int a = 0; a < 32; a++) rc(5'(a), exp_rd(5'(a)));
        chk_cfg();
        $display("test reset done");
        for (int i = 0; i < 60; i++) begin
            x = xs();
            wr({1'b0, x[3:0]}, x[4] ? 8'h00 : x[15:8]);
            rc({1'b0, x[3:0]}, exp_rd({1'b0, x[3:0]}));
        end
        chk_cfg();
        wr(5'h11, 8'hFF);
        rc(5'h11, 8'h15);
        for (int r = 0; r < 8; r++) begin
            wr(5'(6 + r % 4), 8'hF0 | 8'(r));
            wr(5'(2 + r % 4), fn[r]);
            chk_cfg();
        end
        $display("test access done");
        wr(5'h00, 8'h4F);
        for (int p = 0; p < 4; p++) wr(5'(2 + p), 8'h26);
        for (int p = 0; p < 4; p++) wr(5'(6 + p), 8'h00);
        repeat (10) @(posedge clk);
        n0 = got_n;
        slow <= 1'b1;
        fe_wire_break <= 8'h08;
        repeat (3) @(posedge clk);
        fe_overflow <= 8'h01;
        repeat (3) @(posedge clk);
        slow <= 1'b0;
        for (int i = 0; i < 50 && got_n < n0 + 4; i++) @(posedge clk);
        chk("message", 32'h0000_1509, got);
        rc(5'h13, 8'h40);
        rc(5'h13, 8'h00);
        rc(5'h10, 8'h0D);
        rc(5'h17, 8'h09);
        rc(5'h18, 8'h08);
        rc(5'h19, 8'h10);
        $display("test message done");
        wr(5'h00, 8'h0F);
        n0 = got_n;
        fe_underflow <= 8'h10;
        repeat (20) @(posedge clk);
        chk("message count", n0, got_n);
        rc(5'h1A, 8'h04);
        @(posedge clk);
        nv_load      <= 1'b1;
        nv_load_addr <= 4'h6;
        nv_load_data <= 8'hF3;
        @(posedge clk);
        nv_load <= 1'b0;
        rc(5'h06, 8'h03);
        $display("test restore done");
        tally_and_finish();
    end
    // Cuts a hang short
    initial begin
        #200000;
        n_mismatch++;
        tally_and_finish();
    end
endmodule // aipd_bank_tb
`default_nettype wire
